// file: logic/sdlso_defs.vh
// Constants for the SerDes lane status and override register block
`ifndef SDLSO_DEFS_VH
`define SDLSO_DEFS_VH

`define SDLSO_ADDR_W 12
`define SDLSO_BASE 12'h800
`define SDLSO_OFF_STAT 12'h000
`define SDLSO_OFF_OUT 12'h004
`define SDLSO_OFF_IRQ_STAT 12'h040
`define SDLSO_OFF_IRQ_MASK 12'h044

`define SDLSO_STAT_TOP 31:30
`define SDLSO_STAT_TOP_RST 2'h1
`define SDLSO_STAT_LOSF 29:28
`define SDLSO_STAT_RSV27 27:24
`define SDLSO_STAT_RXEQ 23:21
`define SDLSO_STAT_ALIGN 19
`define SDLSO_STAT_HALF 16
`define SDLSO_STAT_MID 15:10
`define SDLSO_STAT_MID_RST 6'h20
`define SDLSO_STAT_BOOST 9:6

`define SDLSO_OUT_OVR 31
`define SDLSO_OUT_RSV 30:26
`define SDLSO_OUT_BOOST 25:22
`define SDLSO_OUT_BOOST_RST 4'h0
`define SDLSO_OUT_PRES 21:3
`define SDLSO_OUT_SLOSS 2

`define SDLSO_IRQ_W 2
`define SDLSO_IRQ_FIELD 1:0
`define SDLSO_IRQ_SLOSS_RISE 0
`define SDLSO_IRQ_SLOSS_FALL 1

`endif

// file: logic/sdlso_sync_edge.v
// Edge detector on a sampled level, one flag per edge direction
`timescale 1ns/1ns
`default_nettype none

module sdlso_sync_edge (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_level,
    output reg o_level_q,
    output wire o_rise,
    output wire o_fall
);

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_level_q <= 1'b0;
        end else begin
            o_level_q <= i_level;
        end
    end

    assign o_rise = i_level & ~o_level_q;
    assign o_fall = ~i_level & o_level_q;

endmodule // sdlso_sync_edge

`default_nettype wire

// file: logic/sdlso_lane_regs.v
// Register bank for one SerDes lane: default status and transmit override
`timescale 1ns/1ns
`default_nettype none
`include "sdlso_defs.vh"

module sdlso_lane_regs (
    input wire i_clock,
    input wire i_rst_n,
    input wire [11:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    input wire [1:0] i_signal_loss_filter_mode,
    input wire [2:0] i_receive_equaliser_setting,
    input wire i_align_enable,
    input wire i_half_rate,
    input wire [3:0] i_tx_boost_default,
    input wire i_signal_loss_indicator,
    output reg [3:0] o_tx_boost,
    output reg o_transmit_override_enable,
    output reg o_irq
);

    // ------------------------------------------------------------
    // Captured defaults
    // ------------------------------------------------------------
    reg [1:0] losf_q;
    reg [1:0] losf_d;
    reg [2:0] rxeq_q;
    reg [2:0] rxeq_d;
    reg align_q;
    reg align_d;
    reg half_q;
    reg half_d;
    reg [3:0] dflt_boost_q;
    reg [3:0] dflt_boost_d;
    reg rst_seen_q;
    reg rst_seen_d;

    // Taken once, on the first clock out of reset
    always @* begin
        rst_seen_d = rst_seen_q;
        losf_d = losf_q;
        rxeq_d = rxeq_q;
        align_d = align_q;
        half_d = half_q;
        dflt_boost_d = dflt_boost_q;
        if (!rst_seen_q) begin
            rst_seen_d = 1'b1;
            losf_d = i_signal_loss_filter_mode;
            rxeq_d = i_receive_equaliser_setting;
            align_d = i_align_enable;
            half_d = i_half_rate;
            dflt_boost_d = i_tx_boost_default;
        end
    end

    // Later moves on the lane levels never reach the status word
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            rst_seen_q <= 1'b0;
            losf_q <= 2'h0;
            rxeq_q <= 3'h0;
            align_q <= 1'b0;
            half_q <= 1'b0;
            dflt_boost_q <= 4'h0;
        end else begin
            rst_seen_q <= rst_seen_d;
            losf_q <= losf_d;
            rxeq_q <= rxeq_d;
            align_q <= align_d;
            half_q <= half_d;
            dflt_boost_q <= dflt_boost_d;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [11:0] rel;
    wire in_window;
    reg hit_stat;
    reg hit_out;
    reg hit_istat;
    reg hit_imask;

    assign in_window = (i_addr >= `SDLSO_BASE);
    assign rel = i_addr - `SDLSO_BASE;

    // Below the base or off the map selects nothing
    always @* begin
        hit_stat = 1'b0;
        hit_out = 1'b0;
        hit_istat = 1'b0;
        hit_imask = 1'b0;
        if (in_window) begin
            case (rel)
                `SDLSO_OFF_STAT: begin
                    hit_stat = 1'b1;
                end
                `SDLSO_OFF_OUT: begin
                    hit_out = 1'b1;
                end
                `SDLSO_OFF_IRQ_STAT: begin
                    hit_istat = 1'b1;
                end
                `SDLSO_OFF_IRQ_MASK: begin
                    hit_imask = 1'b1;
                end
                default: begin
                    hit_stat = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output status and override register
    // ------------------------------------------------------------
    reg ovr_q;
    reg ovr_d;
    reg [4:0] rsv_q;
    reg [4:0] rsv_d;
    reg [3:0] boost_q;
    reg [3:0] boost_d;
    reg [18:0] pres_q;
    reg [18:0] pres_d;

    // Bits 31 to 3 written; loss bit and bits 1:0 have no storage
    always @* begin
        ovr_d = ovr_q;
        rsv_d = rsv_q;
        boost_d = boost_q;
        pres_d = pres_q;
        if (i_wr && hit_out) begin
            ovr_d = i_wdata[`SDLSO_OUT_OVR];
            rsv_d = i_wdata[`SDLSO_OUT_RSV];
            boost_d = i_wdata[`SDLSO_OUT_BOOST];
            pres_d = i_wdata[`SDLSO_OUT_PRES];
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            ovr_q <= 1'b0;
            rsv_q <= 5'h00;
            boost_q <= `SDLSO_OUT_BOOST_RST;
            pres_q <= 19'h00000;
        end else begin
            ovr_q <= ovr_d;
            rsv_q <= rsv_d;
            boost_q <= boost_d;
            pres_q <= pres_d;
        end
    end

    // ------------------------------------------------------------
    // Applied transmit controls
    // ------------------------------------------------------------
    reg [3:0] tx_boost_d;
    reg ovr_en_d;

    // Code zero passes through as no boost to the lane
    always @* begin
        ovr_en_d = ovr_q;
        tx_boost_d = dflt_boost_q;
        if (ovr_q) begin
            tx_boost_d = boost_q;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_tx_boost <= 4'h0;
            o_transmit_override_enable <= 1'b0;
        end else begin
            o_tx_boost <= tx_boost_d;
            o_transmit_override_enable <= ovr_en_d;
        end
    end

    // ------------------------------------------------------------
    // Loss indicator events
    // ------------------------------------------------------------
    wire sloss_q;
    wire sloss_rise;
    wire sloss_fall;
    reg [1:0] istat_q;
    reg [1:0] istat_d;
    reg [1:0] imask_q;
    reg [1:0] imask_d;
    reg irq_d;
    reg [1:0] ev;
    reg [1:0] clr;

    sdlso_sync_edge sdlso_sync_edge_inst (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_level(i_signal_loss_indicator),
        .o_level_q(sloss_q),
        .o_rise(sloss_rise),
        .o_fall(sloss_fall)
    );

    always @* begin
        ev = 2'h0;
        ev[`SDLSO_IRQ_SLOSS_RISE] = sloss_rise;
        ev[`SDLSO_IRQ_SLOSS_FALL] = sloss_fall;
        clr = 2'h0;
        if (i_wr && hit_istat) begin
            clr = i_wdata[`SDLSO_IRQ_FIELD];
        end
    end

    // Set wins over a simultaneous clear; level uses next mask
    always @* begin
        istat_d = (istat_q & ~clr) | ev;
        imask_d = imask_q;
        if (i_wr && hit_imask) begin
            imask_d = i_wdata[`SDLSO_IRQ_FIELD];
        end
        irq_d = |(istat_d & imask_d);
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            istat_q <= 2'h0;
            imask_q <= 2'h0;
            o_irq <= 1'b0;
        end else begin
            istat_q <= istat_d;
            imask_q <= imask_d;
            o_irq <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Read path; status word has no write path at all
    // ------------------------------------------------------------
    reg [31:0] stat_word;
    reg [31:0] out_word;
    reg [31:0] rd_d;
    reg [31:0] rdata_d;

    // Fixed and captured fields laid in bit order; none overlap
    always @* begin
        stat_word = 32'h0;
        stat_word[`SDLSO_STAT_TOP] = `SDLSO_STAT_TOP_RST;
        stat_word[`SDLSO_STAT_LOSF] = losf_q;
        stat_word[`SDLSO_STAT_RXEQ] = rxeq_q;
        stat_word[`SDLSO_STAT_ALIGN] = align_q;
        stat_word[`SDLSO_STAT_HALF] = half_q;
        stat_word[`SDLSO_STAT_MID] = `SDLSO_STAT_MID_RST;
        stat_word[`SDLSO_STAT_BOOST] = dflt_boost_q;
    end

    always @* begin
        out_word = 32'h0;
        out_word[`SDLSO_OUT_OVR] = ovr_q;
        out_word[`SDLSO_OUT_RSV] = rsv_q;
        out_word[`SDLSO_OUT_BOOST] = boost_q;
        out_word[`SDLSO_OUT_PRES] = pres_q;
        out_word[`SDLSO_OUT_SLOSS] = sloss_q;
    end

    always @* begin
        rd_d = 32'h0;
        if (hit_stat) begin
            rd_d = stat_word;
        end else if (hit_out) begin
            rd_d = out_word;
        end else if (hit_istat) begin
            rd_d[`SDLSO_IRQ_FIELD] = istat_q;
        end else if (hit_imask) begin
            rd_d[`SDLSO_IRQ_FIELD] = imask_q;
        end
    end

    // Read data stands one cycle, zero otherwise
    always @* begin
        rdata_d = 32'h0;
        if (i_rd) begin
            rdata_d = rd_d;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0;
        end else begin
            o_rdata <= rdata_d;
        end
    end

endmodule // sdlso_lane_regs

`default_nettype wire

// file: verif/sdlso_lane_regs_assertions.sv
// Checker on the lane register bank ports
`timescale 1ns/1ns
`default_nettype none
module sdlso_lane_regs_chk (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_signal_loss_indicator,
    input wire logic [3:0] o_tx_boost,
    input wire logic o_transmit_override_enable
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire logic wo = i_wr && i_addr == 12'h804;
    wire logic sloss = i_signal_loss_indicator;
    a_ovr_follow: assert property (wo |-> ##2
        o_transmit_override_enable == $past(i_wdata[31], 2))
        else $error("override enable not applied");
    a_boost_ovr: assert property (wo && i_wdata[31] |-> ##2
        o_tx_boost == $past(i_wdata[25:22], 2))
        else $error("override boost not applied");
    a_ovr_change: assert property ($changed(o_transmit_override_enable)
        |-> $past(wo, 2)) else $error("override enable moved alone");
    a_boost_change: assert property ($changed(o_tx_boost) |-> $past(wo, 2)
        || !($past(i_rst_n, 1) && $past(i_rst_n, 2) && $past(i_rst_n, 3)))
        else $error("boost moved without a write");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_unmapped_zero: assert property (i_rd && !(i_addr inside
        {12'h800, 12'h804, 12'h840, 12'h844}) |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_loss_bit: assert property (i_rd && i_addr == 12'h804 && $stable(sloss)
        && sloss == $past(sloss, 2) |=> o_rdata[2] == $past(sloss))
        else $error("loss bit wrong");
    a_stat_fixed: assert property (i_rd && i_addr == 12'h800 |=>
        o_rdata[31:30] == 2'h1 && o_rdata[15:10] == 6'h20)
        else $error("status fixed bits wrong");
endmodule // sdlso_lane_regs_chk
bind sdlso_lane_regs sdlso_lane_regs_chk sdlso_lane_regs_chk_inst (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_signal_loss_indicator(i_signal_loss_indicator),
    .o_tx_boost(o_tx_boost),
    .o_transmit_override_enable(o_transmit_override_enable));
`default_nettype wire

// file: verif/serdes_lane_status_override_tb.sv
// Register-level testbench for the lane register bank
`timescale 1ns/1ns
`default_nettype none
module serdes_lane_status_override_tb;
    logic i_clock = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
    logic [11:0] i_addr = 12'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [1:0] lf = 2'h2;
    logic [2:0] eq = 3'h5;
    logic al = 1, hr = 1, sloss = 0;
    logic [3:0] bd = 4'hb;
    wire [31:0] o_rdata;
    wire [3:0] o_tx_boost;
    wire ovr, o_irq;
    int n_mismatch = 0, n_tests = 0;
    always #5 i_clock = ~i_clock;
    sdlso_lane_regs sdlso_lane_regs_inst (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_signal_loss_filter_mode(lf),
        .i_receive_equaliser_setting(eq), .i_align_enable(al),
        .i_half_rate(hr), .i_tx_boost_default(bd),
        .i_signal_loss_indicator(sloss), .o_tx_boost(o_tx_boost),
        .o_transmit_override_enable(ovr), .o_irq(o_irq));
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge i_clock);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 0;
        #1 chk("rdata", e, o_rdata & m);
    endtask
    task tally_and_finish;
        $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst_n <= 1;
        repeat (3) @(posedge i_clock);
        lf <= 2'h0;
        eq <= 3'h0;
        hr <= 1'h0;
        bd <= 4'h0;
        rd(12'h800, 32'hf0e9ffc0, 32'h60a982c0);
        wr(12'h800, 32'h0);
        rd(12'h800, 32'hf0e9ffc0, 32'h60a982c0);
        #1 chk("boost", 32'hb, 32'(o_tx_boost));
        $display("Test status word done");
        rd(12'h804, 32'hfffffffc, 32'h0);
        wr(12'h804, 32'h83c00000);
        rd(12'h804, 32'hfffffffc, 32'h83c00000);
        chk("boost", 32'h1f, {27'h0, o_tx_boost, ovr});
        wr(12'h804, 32'h80000000);
        #15 chk("boost", 32'h0, 32'(o_tx_boost));
        wr(12'h804, 32'h002aaaac);
        rd(12'h804, 32'hfffffffc, 32'h002aaaa8);
        chk("boost", 32'h16, {27'h0, o_tx_boost, ovr});
        rd(12'h808, 32'hffffffff, 32'h0);
        $display("Test override word done");
        wr(12'h844, 32'h1);
        sloss <= 1'h1;
        repeat (3) @(posedge i_clock);
        rd(12'h804, 32'h4, 32'h4);
        chk("irq", 32'h1, 32'(o_irq));
        rd(12'h840, 32'h1, 32'h1);
        wr(12'h840, 32'h1);
        sloss <= 1'h0;
        repeat (3) @(posedge i_clock);
        #1 chk("irq", 32'h0, 32'(o_irq));
        rd(12'h840, 32'h3, 32'h2);
        $display("Test loss interrupt done");
        tally_and_finish;
    end
    initial begin
        repeat (2000) @(posedge i_clock);
        n_mismatch++;
        tally_and_finish;
    end
endmodule // serdes_lane_status_override_tb
`default_nettype wire
